//--- acmp_core_model.sv
// Purpose: behavioural comparator core beside acmp_ctrl
// Assumes: voltages are 8-bit codes set by the bench
// Notes: powered-off core holds its output low
`timescale 1ns/1ps
module acmp_core_model
#(
    parameter logic [7:0] BG_LEVEL = 8'h80
)
(
    input wire logic [7:0] pos_v_i,
    input wire logic [7:0] neg_v_i,
    input wire logic [63:0] chan_v_i,
    input wire logic power_off_i,
    input wire logic bandgap_i,
    input wire logic use_channel_i,
    input wire logic [2:0] channel_i,
    output logic raw_o
);
    logic [7:0] plus;
    logic [7:0] minus;
    // input selection, then the compare itself
    assign plus = bandgap_i ? BG_LEVEL : pos_v_i;
    assign minus = use_channel_i ? chan_v_i[channel_i*8 +: 8] : neg_v_i;
    assign raw_o = !power_off_i && (plus > minus);
endmodule : acmp_core_model

//--- acmp_ctrl.sv
// Purpose: control and status logic around an analog comparator
// Assumes: comparator core gives a raw async output; 10 MHz clk_i
// Notes: analog selects leave as registered control outputs
// Operation
// - compare_result is one when the positive input is above the negative.
// - with mux enable set and converter off, channel_select picks 0..7.
// - the raw output is synchronised, one to two cycles of latency.
// - the event flag sets on the event kind chosen by irq_edge_select.
// - edge select 00 toggle, 01 reserved, 10 falling, 11 rising.
// - the event flag clears when its interrupt vector is taken.
// - writing one to the event flag clears it, zero leaves it.
// - compare_irq_o is requested only with irq enable and global enable; irq_o needs only the mask bit.
// - capture routing connects the result to the timer capture input.
// - bandgap select swaps the positive input for the reference.
// - power off removes comparator power and may change at any time.
// - a pin input disable bit turns off its buffer and reads port zero.
// - the converter mux serves the comparator only with power reduce off.
`timescale 1ns/1ps
module acmp_ctrl
    import acmp_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    // register port
    input wire logic [acmp_pkg::ADDR_W-1:0] addr_i,
    input wire logic [acmp_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [acmp_pkg::DATA_W-1:0] rdata_o,
    // system context
    input wire logic global_irq_en_i,
    input wire logic vector_taken_i,
    input wire logic converter_power_reduce_i,
    // comparator core
    input wire logic cmp_raw_i,
    input wire logic [1:0] pin_level_i,
    // analog controls
    output logic comparator_power_off_o,
    output logic bandgap_select_o,
    output logic use_channel_o,
    output logic [2:0] channel_select_o,
    output logic [1:0] pin_input_disable_o,
    output logic [1:0] port_pin_o,
    // timer and interrupts
    output logic capture_input_o,
    output logic compare_irq_o,
    output logic irq_o
);
    import acmp_pkg::*;

    logic [7:0] conv_ctrl_b;
    logic [7:0] cmp_ctrl;
    logic [7:0] dig_dis;
    logic [7:0] irq_mask;
    logic converter_enable;
    logic [2:0] channel_select;
    logic cmp_sync;
    logic cmp_prev;
    logic compare_event_flag;
    logic event_hit;
    logic wr_cmp;
    logic [7:0] next_rdata;
    logic [7:0] status_view;

    // address match helper used by every write decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    assign wr_cmp = wr_i && hit(addr_i, OFF_CMP_CTRL);

    // raw comparator output crosses into clk_i
    acmp_sync u_sync
    (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .async_i(cmp_raw_i),
        .sync_o(cmp_sync)
    );

    // previous sample for edge detection
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            cmp_prev <= 1'b0;
        else if (ce_i)
            cmp_prev <= cmp_sync;
    end

    // event decode; reserved code never fires
    always_comb
    begin
        case (edge_mode_t'(cmp_ctrl[EDGE_HI:EDGE_LO]))
            EDGE_TOGGLE: event_hit = cmp_sync ^ cmp_prev;
            EDGE_FALL: event_hit = cmp_prev & ~cmp_sync;
            EDGE_RISE: event_hit = ~cmp_prev & cmp_sync;
            default: event_hit = 1'b0;
        endcase
    end

    // event flag: a fresh event wins over any clear in the same cycle
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            compare_event_flag <= 1'b0;
        else if (ce_i)
        begin
            if (event_hit)
                compare_event_flag <= 1'b1;
            else if (vector_taken_i && compare_irq_o)
                compare_event_flag <= 1'b0;
            else if (wr_cmp && wdata_i[FLAG_BIT])
                compare_event_flag <= 1'b0;
        end
    end

    // comparator control register; writes need no sequencing in hardware
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            cmp_ctrl <= RST_CMP_CTRL;
        else if (ce_i && wr_cmp)
            cmp_ctrl <= wdata_i;
    end

    // converter control b; bits 7, 5 and 4 stay zero
    // so software reads back only what the hardware keeps
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            conv_ctrl_b <= RST_CONV_CTRL_B;
        else if (ce_i && wr_i && hit(addr_i, OFF_CONV_CTRL_B))
            conv_ctrl_b <= wdata_i & MASK_CONV_CTRL_B;
    end

    // digital input disables, two pins only
    // the analog pins save buffer power while these are set
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            dig_dis <= RST_DIG_DIS;
        else if (ce_i && wr_i && hit(addr_i, OFF_DIG_DIS))
            dig_dis <= wdata_i & MASK_DIG_DIS;
    end

    // converter enable; a running converter owns the mux
    // so the comparator falls back to the negative pin
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            converter_enable <= 1'b0;
        else if (ce_i && wr_i && hit(addr_i, OFF_CONV_CTRL_A))
            converter_enable <= wdata_i[CONV_EN_BIT];
    end

    // channel select, shared with the converter mux
    // only the three low bits matter to the comparator
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            channel_select <= RST_MUX[2:0];
        else if (ce_i && wr_i && hit(addr_i, OFF_CONV_MUX))
            channel_select <= wdata_i[2:0];
    end

    // interrupt mask for the level output, bit 0 only
    // mask reset matches the other control words: all clear
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            irq_mask <= RST_DIG_DIS;
        else if (ce_i && wr_i && hit(addr_i, OFF_IRQ_MASK))
            irq_mask <= {7'h00, wdata_i[0]};
    end

    // status view: live result, sticky flag, the rest as written
    always_comb
    begin
        status_view = cmp_ctrl;
        status_view[RESULT_BIT] = cmp_sync;
        status_view[FLAG_BIT] = compare_event_flag;
    end

    // read mux, data valid the cycle after the strobe
    always_comb
    begin
        next_rdata = 8'h00;
        if (hit(addr_i, OFF_CMP_CTRL))
            next_rdata = status_view;
        else if (hit(addr_i, OFF_CONV_CTRL_B))
            next_rdata = conv_ctrl_b;
        else if (hit(addr_i, OFF_DIG_DIS))
            next_rdata = dig_dis;
        else if (hit(addr_i, OFF_CONV_CTRL_A))
            next_rdata = {converter_enable, 7'h00};
        else if (hit(addr_i, OFF_CONV_MUX))
            next_rdata = {5'h00, channel_select};
        else if (hit(addr_i, OFF_IRQ_MASK))
            next_rdata = irq_mask;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rdata_o <= 8'h00;
        else if (ce_i)
            rdata_o <= rd_i ? next_rdata : 8'h00;
    end

    // power off follows its bit one cycle after the write
    // no interlock: software masks the interrupt first
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            comparator_power_off_o <= 1'b0;
        else if (ce_i)
            comparator_power_off_o <= cmp_ctrl[PWR_OFF_BIT];
    end

    // bandgap swap for the positive input
    // the reference needs settling time before results are trusted
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            bandgap_select_o <= 1'b0;
        else if (ce_i)
            bandgap_select_o <= cmp_ctrl[BG_SEL_BIT];
    end

    // mux use needs enable, converter off and power reduce clear
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            use_channel_o <= 1'b0;
        else if (ce_i)
            use_channel_o <= conv_ctrl_b[MSE_BIT] && !converter_enable
                && !converter_power_reduce_i;
    end

    // channel index to the analog mux
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            channel_select_o <= 3'h0;
        else if (ce_i)
            channel_select_o <= channel_select;
    end

    // buffer disables to the pad cells
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            pin_input_disable_o <= 2'h0;
        else if (ce_i)
            pin_input_disable_o <= dig_dis[1:0];
    end

    // pin levels are asynchronous: two flops before any use
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pin_s1 <= 2'h0;
            pin_s2 <= 2'h0;
        end
        else if (ce_i)
        begin
            pin_s1 <= pin_level_i;
            pin_s2 <= pin_s1;
        end
    end

    // port readback; disabled pins read zero
    // masking after the sync keeps a floating pad from leaking
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            port_pin_o <= 2'h0;
        else if (ce_i)
            port_pin_o <= pin_s2 & ~dig_dis[1:0];
    end

    // capture routing: no connection at all while routing is off
    // the timer's own filter handles noise on this path
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            capture_input_o <= 1'b0;
        else if (ce_i)
            capture_input_o <= cmp_ctrl[CAP_EN_BIT] & cmp_sync;
    end

    // comparator request needs local and global enable
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            compare_irq_o <= 1'b0;
        else if (ce_i)
            compare_irq_o <= compare_event_flag && cmp_ctrl[IRQ_EN_BIT]
                && global_irq_en_i;
    end

    // level interrupt: flag gated by the mask register
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            irq_o <= 1'b0;
        else if (ce_i)
            irq_o <= compare_event_flag && irq_mask[0];
    end
endmodule : acmp_ctrl

//--- acmp_ctrl_chk.sv
// Purpose: port checks for acmp_ctrl
// Assumes: ce_i held high
// Notes: attached by bind at the foot
`timescale 1ns/1ps
module acmp_ctrl_chk
    import acmp_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [acmp_pkg::ADDR_W-1:0] addr_i,
    input wire logic [acmp_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [acmp_pkg::DATA_W-1:0] rdata_o,
    input wire logic global_irq_en_i,
    input wire logic vector_taken_i,
    input wire logic converter_power_reduce_i,
    input wire logic cmp_raw_i,
    input wire logic bandgap_select_o,
    input wire logic use_channel_o,
    input wire logic [2:0] channel_select_o,
    input wire logic [1:0] pin_input_disable_o,
    input wire logic [1:0] port_pin_o,
    input wire logic capture_input_o,
    input wire logic compare_irq_o
);
    logic [2:0] quiet;
    // steady-edge count: a new event would mask a vector clear
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            quiet <= 3'h0;
        else if (cmp_raw_i != $past(cmp_raw_i))
            quiet <= 3'h0;
        else if (quiet != 3'h7)
            quiet <= quiet + 3'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_wr(logic [7:0] a);
        wr_i && addr_i == a;
    endsequence
    sequence s_vec;
        vector_taken_i && compare_irq_o && quiet >= 3'h4;
    endsequence
    a_irq_global: assert property (
        compare_irq_o |-> $past(global_irq_en_i))
        else $error("irq without global enable");
    a_vec_clear: assert property (s_vec |-> ##2 !compare_irq_o)
        else $error("vector did not clear irq");
    a_cap_follow: assert property (
        capture_input_o |-> $past(cmp_raw_i, 3))
        else $error("capture without result");
    a_rd_idle: assert property (
        !$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside slot");
    a_bg_mirror: assert property (
        s_wr(OFF_CMP_CTRL) |-> ##2
        bandgap_select_o == $past(wdata_i[BG_SEL_BIT], 2))
        else $error("bandgap select wrong");
    a_chan_mirror: assert property (
        s_wr(OFF_CONV_MUX) |-> ##2
        channel_select_o == $past(wdata_i[2:0], 2))
        else $error("channel select wrong");
    a_dis_mirror: assert property (
        s_wr(OFF_DIG_DIS) |-> ##2
        pin_input_disable_o == $past(wdata_i[1:0], 2))
        else $error("input disable wrong");
    a_pin_masked: assert property (
        pin_input_disable_o[0] && $past(pin_input_disable_o[0])
        && $past(pin_input_disable_o[0], 2) |-> !port_pin_o[0])
        else $error("disabled pin reads one");
    a_mux_blocked: assert property (
        converter_power_reduce_i && $past(converter_power_reduce_i)
        |-> !use_channel_o)
        else $error("mux used in power reduce");
endmodule : acmp_ctrl_chk
bind acmp_ctrl acmp_ctrl_chk acmp_ctrl_chk_i (.clk_i, .arst_n_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .global_irq_en_i,
    .vector_taken_i, .converter_power_reduce_i, .cmp_raw_i,
    .bandgap_select_o, .use_channel_o, .channel_select_o,
    .pin_input_disable_o, .port_pin_o, .capture_input_o,
    .compare_irq_o);

//--- acmp_pkg.sv
// Purpose: shared constants for the analog comparator control block
// Assumes: 8-bit register port, one system clock
// Notes: offsets are register addresses on the plain port
package acmp_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // register offsets
    localparam logic [7:0] OFF_CONV_CTRL_B = 8'h7B;
    localparam logic [7:0] OFF_CMP_CTRL = 8'h50;
    localparam logic [7:0] OFF_DIG_DIS = 8'h7F;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h51;
    localparam logic [7:0] OFF_CONV_CTRL_A = 8'h7A;
    localparam logic [7:0] OFF_CONV_MUX = 8'h7C;
    // converter_control_b fields
    localparam int MSE_BIT = 6;
    // comparator_control_status fields
    localparam int PWR_OFF_BIT = 7;
    localparam int BG_SEL_BIT = 6;
    localparam int RESULT_BIT = 5;
    localparam int FLAG_BIT = 4;
    localparam int IRQ_EN_BIT = 3;
    localparam int CAP_EN_BIT = 2;
    localparam int EDGE_HI = 1;
    localparam int EDGE_LO = 0;
    // converter control a: enable bit
    localparam int CONV_EN_BIT = 7;
    // reset values
    localparam logic [7:0] RST_CONV_CTRL_B = 8'h00;
    localparam logic [7:0] RST_CMP_CTRL = 8'h00;
    localparam logic [7:0] RST_DIG_DIS = 8'h00;
    localparam logic [7:0] RST_MUX = 8'h00;
    // write masks
    localparam logic [7:0] MASK_CONV_CTRL_B = 8'h4F;
    localparam logic [7:0] MASK_DIG_DIS = 8'h03;
    // synchroniser depth in cycles
    localparam int SYNC_STAGES = 2;
    typedef enum logic [1:0]
    {
        EDGE_TOGGLE = 2'b00,
        EDGE_RSVD = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_RISE = 2'b11
    } edge_mode_t;
endpackage : acmp_pkg

//--- acmp_sync.sv
// Purpose: two-stage synchroniser for one asynchronous level
// Assumes: clk_i domain, input from outside the domain
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module acmp_sync
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic async_i,
    output logic sync_o
);
    logic meta;

    // two flops, nothing taps the first
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta <= 1'b0;
            sync_o <= 1'b0;
        end
        else if (ce_i)
        begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule : acmp_sync

//--- analog_comparator_control_tb_top.sv
// Purpose: register-level bench for acmp_ctrl
// Assumes: ce_i held high, core model drives cmp_raw_i
// Notes: settle covers sync, flag and irq stages
`timescale 1ns/1ps
module analog_comparator_control_tb_top;
    import acmp_pkg::*;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic wr_i = 1'b0, rd_i = 1'b0, global_irq_en_i = 1'b0;
    logic vector_taken_i = 1'b0, converter_power_reduce_i = 1'b0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, pos_v = 8'h10, d, rdata_o;
    logic [1:0] pin_level_i = 2'h0, pin_input_disable_o, port_pin_o;
    logic [2:0] channel_select_o;
    logic cmp_raw_i, comparator_power_off_o, bandgap_select_o, use_channel_o;
    logic capture_input_o, compare_irq_o, irq_o;
    int bad_count = 0, num_checks = 0, cycles = 0;
    always #50 clk_i = ~clk_i;
    acmp_ctrl acmp_ctrl_i (.clk_i, .arst_n_i, .ce_i(1'b1), .addr_i, .wdata_i,
        .wr_i, .rd_i, .rdata_o, .global_irq_en_i, .vector_taken_i,
        .converter_power_reduce_i, .cmp_raw_i, .pin_level_i,
        .comparator_power_off_o, .bandgap_select_o, .use_channel_o,
        .channel_select_o, .pin_input_disable_o, .port_pin_o,
        .capture_input_o, .compare_irq_o, .irq_o);
    acmp_core_model acmp_core_model_i (.pos_v_i(pos_v), .neg_v_i(8'h40),
        .chan_v_i(64'h0000F00000000000), .power_off_i(comparator_power_off_o),
        .bandgap_i(bandgap_select_o), .use_channel_i(use_channel_o),
        .channel_i(channel_select_o), .raw_o(cmp_raw_i));
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one-cycle strobes, data taken in the slot after the read
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        d = rdata_o;
    endtask : rd
    task settle;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
    endtask : settle
    task setpos(input logic [7:0] v);
        @(posedge clk_i);
        pos_v <= v;
        settle();
    endtask : setpos
    task pulse_vec;
        @(posedge clk_i);
        vector_taken_i <= 1'b1;
        @(posedge clk_i);
        vector_taken_i <= 1'b0;
    endtask : pulse_vec
    // hang guard, far above the run length
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (12) @(posedge clk_i);
        arst_n_i <= 1'b1;
        rd(OFF_CMP_CTRL); chk("status", d, RST_CMP_CTRL);
        rd(OFF_CONV_CTRL_B); chk("ctrl b", d, RST_CONV_CTRL_B);
        rd(8'h10); chk("unmapped", d, 8'h00);
        // every edge code, rising then falling output
        for (int m = 0; m < 4; m++)
        begin
            wr(OFF_CMP_CTRL, 8'(8'h10 | m));
            setpos(8'h90);
            rd(OFF_CMP_CTRL); chk("result", 8'(d[RESULT_BIT]), 8'h01);
            chk("rise flag", 8'(d[FLAG_BIT]), 8'(m == 0 || m == 3));
            wr(OFF_CMP_CTRL, 8'(8'h10 | m));
            setpos(8'h10);
            rd(OFF_CMP_CTRL); chk("fall flag", 8'(d[FLAG_BIT]), 8'(m == 0 || m == 2));
        end
        wr(OFF_CMP_CTRL, 8'h18);
        wr(OFF_IRQ_MASK, 8'h01);
        rd(OFF_IRQ_MASK); chk("mask", d, 8'h01);
        global_irq_en_i <= 1'b1;
        setpos(8'h90);
        chk("cmp irq", 8'(compare_irq_o), 8'h01);
        chk("irq", 8'(irq_o), 8'h01);
        wr(OFF_IRQ_MASK, 8'h00); settle();
        chk("irq masked", 8'(irq_o), 8'h00);
        wr(OFF_CMP_CTRL, 8'h08);
        rd(OFF_CMP_CTRL); chk("w0 flag", 8'(d[FLAG_BIT]), 8'h01);
        global_irq_en_i <= 1'b0; settle();
        chk("no gie", 8'(compare_irq_o), 8'h00);
        global_irq_en_i <= 1'b1; settle();
        pulse_vec(); settle();
        rd(OFF_CMP_CTRL); chk("vec flag", 8'(d[FLAG_BIT]), 8'h00);
        wr(OFF_CMP_CTRL, 8'h04); settle();
        chk("capture", 8'(capture_input_o), 8'h01);
        wr(OFF_CMP_CTRL, 8'h00); settle();
        chk("no capture", 8'(capture_input_o), 8'h00);
        setpos(8'h10);
        wr(OFF_CMP_CTRL, 8'h40); settle();
        rd(OFF_CMP_CTRL); chk("bandgap", 8'(d[RESULT_BIT]), 8'h01);
        chk("bg pin", 8'(bandgap_select_o), 8'h01);
        wr(OFF_CMP_CTRL, 8'hC0); settle();
        rd(OFF_CMP_CTRL); chk("power off", 8'(d[RESULT_BIT]), 8'h00);
        chk("power pin", 8'(comparator_power_off_o), 8'h01);
        wr(OFF_CMP_CTRL, 8'h00);
        setpos(8'h80);
        wr(OFF_CONV_CTRL_B, 8'hFF);
        rd(OFF_CONV_CTRL_B); chk("ctrl b mask", d, MASK_CONV_CTRL_B);
        wr(OFF_CONV_MUX, 8'h05); settle();
        rd(OFF_CMP_CTRL); chk("channel 5", 8'(d[RESULT_BIT]), 8'h00);
        chk("use chan", 8'(use_channel_o), 8'h01);
        chk("chan pin", 8'(channel_select_o), 8'h05);
        wr(OFF_CONV_CTRL_A, 8'h80); settle();
        rd(OFF_CMP_CTRL); chk("conv on", 8'(d[RESULT_BIT]), 8'h01);
        wr(OFF_CONV_CTRL_A, 8'h00); settle();
        converter_power_reduce_i <= 1'b1; settle();
        rd(OFF_CMP_CTRL); chk("reduce", 8'(d[RESULT_BIT]), 8'h01);
        chk("reduce pin", 8'(use_channel_o), 8'h00);
        pin_level_i <= 2'h3;
        wr(OFF_DIG_DIS, 8'h01); settle();
        chk("pins", 8'(port_pin_o), 8'h02);
        chk("dis pin", 8'(pin_input_disable_o), 8'h01);
        wrap_up();
    end
endmodule : analog_comparator_control_tb_top
